/* File: core/smm_regs.svh */
//==============================================================
// Behaviour
// - Unit is bus master while master enable and unit enable bits are both one.
// - Data write loads transmit buffer; empty shifter takes it and starts.
// - Byte shifts out on MOSI while master drives SCK.
// - Transfer end sets completion flag; interrupt request if enabled.
// - MISO enters MSB first; full byte copied to receive buffer.
// - Mode hi=0, lo=1 is default multi-master; select pin is input.
// - Multi-master low select clears both enables and sets mode fault.
// - Mode fault interrupts if enabled; unit stays off until re-enabled.
// - Both mode bits zero: 3-wire, select unused and not driven.
// - Mode hi one: 4-wire, select pin driven as output.
// - In 4-wire mode select output follows mode lo bit.
`ifndef SMM_REGS_SVH
`define SMM_REGS_SVH
`define SMM_CTRL_MODF 5
`define SMM_CTRL_MSTEN 6
`define SMM_CTRL_DONE 7
`define SMM_CTRL_MDHI 3
`define SMM_CTRL_MDLO 2
`define SMM_CTRL_EN 0
`define SMM_RST_MDHI 1'h0
`define SMM_RST_MDLO 1'h1
`define SMM_BITS 4'h8
`define SMM_DIV_W 8
`endif

/* File: core/smm_pkg.sv */
//==============================================================
// Shared types
package smm_pkg;
    typedef enum logic [1:0] {SMM_IDLE, SMM_LEAD, SMM_TRAIL} smm_state_t;
    typedef enum logic [1:0] {SMM_MM, SMM_3W, SMM_4W} smm_sel_t;
endpackage : smm_pkg

/* File: core/smm_sync.sv */
`timescale 1ns/10ps
//==============================================================
// Two-flop synchroniser
module smm_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta;
    // First stage only feeds second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b1;
            q <= 1'b1;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : smm_sync

/* File: core/smm_buf2.sv */
`timescale 1ns/10ps
//==============================================================
// Two-entry valid/ready buffer
module smm_buf2 (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [7:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [7:0] mem [0:1];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];
    // Pointers and fill count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
    // Storage, no reset needed
    always_ff @(posedge clk) begin
        if (push) mem[wr_ptr] <= in_data;
    end
endmodule : smm_buf2

/* File: core/smm_master.sv */
`timescale 1ns/10ps
`include "smm_regs.svh"
//==============================================================
// Serial master, master-mode control
module smm_master (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Control writes
    input wire logic CTRL_WR,
    input wire logic [7:0] CTRL_WDATA,
    input wire logic [7:0] CLK_DIV,
    input wire logic CLK_POL,
    input wire logic INT_EN,
    // Transmit stream
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    // Receive stream
    output logic [7:0] RX_DATA,
    output logic RX_VALID,
    input wire logic RX_READY,
    // Status
    output logic [7:0] CTRL_STATUS,
    output logic IRQ,
    output logic BUSY,
    // Serial pins
    output logic SCK,
    output logic MOSI,
    input wire logic MISO,
    input wire logic SLAVE_SELECT_N_IN,
    output logic SLAVE_SELECT_N_OUT,
    output logic SLAVE_SELECT_N_OE_N
);
    //==========================================================
    // Control register
    logic master_enable_bit;
    logic unit_enable_bit;
    logic mode_fault_flag;
    logic transfer_done_flag;
    logic select_mode_hi;
    logic select_mode_lo;
    logic ss_sync;
    logic miso_sync;
    smm_pkg::smm_state_t state;
    logic [7:0] shifter;
    logic [3:0] bit_cnt;
    logic [`SMM_DIV_W-1:0] div_cnt;
    logic sck_int;
    logic [7:0] rx_byte;
    logic rx_push;
    logic tx_ready_int;
    logic [7:0] tx_out;
    logic tx_valid_out;
    logic rx_in_ready;
    logic rx_valid_int;
    logic [7:0] rx_data_int;
    logic sample_bit;

    // Mode decode
    wire smm_pkg::smm_sel_t sel_mode = select_mode_hi ? smm_pkg::SMM_4W :
        (select_mode_lo ? smm_pkg::SMM_MM : smm_pkg::SMM_3W);
    wire active = master_enable_bit && unit_enable_bit;
    wire fault = (sel_mode == smm_pkg::SMM_MM) && !ss_sync && active;
    wire div_hit = (div_cnt == CLK_DIV);
    wire start = active && (state == smm_pkg::SMM_IDLE) && tx_valid_out && rx_in_ready;
    wire last_bit = (bit_cnt == `SMM_BITS - 4'h1);
    wire byte_end = (state == smm_pkg::SMM_TRAIL) && div_hit && last_bit;
    // Fill level rebuilt from buffer flags; registered ready never offers a missing slot
    wire tx_push = TX_VALID && TX_READY;
    wire [1:0] tx_fill = !tx_valid_out ? 2'h0 : (tx_ready_int ? 2'h1 : 2'h2);
    wire [1:0] next_tx_fill = tx_fill + {1'b0, tx_push} - {1'b0, start};
    // Output stage reloads when empty or when the reader takes its word
    wire rx_pop = rx_valid_int && (!RX_VALID || RX_READY);

    // Pin synchronisers
    smm_sync u_ss (.clk(CLK), .rst(RST), .d(SLAVE_SELECT_N_IN), .q(ss_sync));
    smm_sync u_miso (.clk(CLK), .rst(RST), .d(MISO), .q(miso_sync));

    // Transmit holding buffer, stalls writer when full
    smm_buf2 u_txb (
        .clk(CLK), .rst(RST),
        .in_data(TX_DATA), .in_valid(tx_push), .in_ready(tx_ready_int),
        .out_data(tx_out), .out_valid(tx_valid_out), .out_ready(start)
    );
    // Receive buffer, a stalled reader holds the next start
    smm_buf2 u_rxb (
        .clk(CLK), .rst(RST),
        .in_data(rx_byte), .in_valid(rx_push), .in_ready(rx_in_ready),
        .out_data(rx_data_int), .out_valid(rx_valid_int), .out_ready(rx_pop)
    );

    //==========================================================
    // Control bits; fault clear beats software set in same cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            master_enable_bit <= 1'b0;
            unit_enable_bit <= 1'b0;
            mode_fault_flag <= 1'b0;
            transfer_done_flag <= 1'b0;
            select_mode_hi <= `SMM_RST_MDHI;
            select_mode_lo <= `SMM_RST_MDLO;
        end else begin
            if (CTRL_WR) begin
                master_enable_bit <= CTRL_WDATA[`SMM_CTRL_MSTEN];
                unit_enable_bit <= CTRL_WDATA[`SMM_CTRL_EN];
                select_mode_hi <= CTRL_WDATA[`SMM_CTRL_MDHI];
                select_mode_lo <= CTRL_WDATA[`SMM_CTRL_MDLO];
                mode_fault_flag <= mode_fault_flag & CTRL_WDATA[`SMM_CTRL_MODF];
                transfer_done_flag <= transfer_done_flag & CTRL_WDATA[`SMM_CTRL_DONE];
            end
            if (fault) begin
                master_enable_bit <= 1'b0;
                unit_enable_bit <= 1'b0;
                mode_fault_flag <= 1'b1;
            end
            if (byte_end) transfer_done_flag <= 1'b1;
        end
    end

    //==========================================================
    // Shift engine: each bit has a lead and trail half of SCK
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= smm_pkg::SMM_IDLE;
            shifter <= 8'h00;
            bit_cnt <= 4'h0;
            div_cnt <= '0;
            sck_int <= 1'b0;
            rx_byte <= 8'h00;
            sample_bit <= 1'b0;
            rx_push <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            div_cnt <= (div_hit || state == smm_pkg::SMM_IDLE) ? '0 : div_cnt + 1'b1;
            unique case (state)
                smm_pkg::SMM_IDLE: begin
                    sck_int <= 1'b0;
                    bit_cnt <= 4'h0;
                    if (start) begin
                        shifter <= tx_out;
                        state <= smm_pkg::SMM_LEAD;
                    end
                end
                smm_pkg::SMM_LEAD: begin
                    if (!active) begin
                        state <= smm_pkg::SMM_IDLE;
                    end else if (div_hit) begin
                        sck_int <= 1'b1;
                        // Sample only; MOSI must hold still across the leading edge
                        sample_bit <= miso_sync;
                        state <= smm_pkg::SMM_TRAIL;
                    end
                end
                smm_pkg::SMM_TRAIL: begin
                    if (!active) begin
                        state <= smm_pkg::SMM_IDLE;
                    end else if (div_hit) begin
                        sck_int <= 1'b0;
                        shifter <= {shifter[6:0], sample_bit};
                        if (last_bit) begin
                            rx_byte <= {shifter[6:0], sample_bit};
                            rx_push <= 1'b1;
                            state <= smm_pkg::SMM_IDLE;
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                            state <= smm_pkg::SMM_LEAD;
                        end
                    end
                end
            endcase
        end
    end

    //==========================================================
    // Registered outputs
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SCK <= 1'b0;
            MOSI <= 1'b0;
            SLAVE_SELECT_N_OUT <= 1'b1;
            SLAVE_SELECT_N_OE_N <= 1'b1;
            CTRL_STATUS <= 8'h00;
            IRQ <= 1'b0;
            BUSY <= 1'b0;
            TX_READY <= 1'b0;
            RX_DATA <= 8'h00;
            RX_VALID <= 1'b0;
        end else begin
            SCK <= sck_int ^ CLK_POL;
            MOSI <= shifter[7];
            SLAVE_SELECT_N_OUT <= select_mode_lo;
            SLAVE_SELECT_N_OE_N <= !(sel_mode == smm_pkg::SMM_4W);
            CTRL_STATUS <= {transfer_done_flag, master_enable_bit, mode_fault_flag, 1'b0,
                            select_mode_hi, select_mode_lo, BUSY, unit_enable_bit};
            IRQ <= INT_EN && (transfer_done_flag || mode_fault_flag);
            BUSY <= (state != smm_pkg::SMM_IDLE);
            TX_READY <= (next_tx_fill != 2'h2);
            if (!RX_VALID || RX_READY) begin
                RX_DATA <= rx_data_int;
                RX_VALID <= rx_valid_int;
            end
        end
    end
endmodule : smm_master

/* File: tb/smm_slave_model.sv */
`timescale 1ns/10ps
//==========
// Slave model: answers with the inverse of the last byte heard
module smm_slave_model (
    input wire logic sck,
    input wire logic pol,
    input wire logic mosi,
    input wire logic sel_n,
    output logic miso
);
    logic [7:0] shreg = 8'h3C;
    logic [7:0] got = 8'h00;
    int n = 0;
    // Leading edge samples, trailing edge shifts
    always @(sck) begin
        if (!sel_n && sck != pol) begin
            got = {got[6:0], mosi};
        end else if (!sel_n) begin
            n = n + 1;
            shreg = (n % 8 == 0) ? ~got : {shreg[6:0], 1'b0};
        end
    end
    // Pulled up while not selected
    assign miso = sel_n ? 1'b1 : shreg[7];
endmodule : smm_slave_model

/* File: tb/smm_master_checker.sv */
`timescale 1ns/10ps
//==========
// Port checks
module smm_master_checker (
    // Clock, reset, levels
    input wire logic CLK,
    input wire logic RST,
    input wire logic INT_EN,
    input wire logic CLK_POL,
    input wire logic TX_VALID,
    // Outputs watched
    input wire logic TX_READY,
    input wire logic RX_VALID,
    input wire logic [7:0] CTRL_STATUS,
    input wire logic IRQ,
    input wire logic BUSY,
    input wire logic SCK,
    input wire logic SLAVE_SELECT_N_IN,
    input wire logic SLAVE_SELECT_N_OUT,
    input wire logic SLAVE_SELECT_N_OE_N
);
    logic [7:0] n_lead;
    logic sck_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Leading edges since busy rose; mod 8 allows back-to-back
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            n_lead <= 8'h00;
            sck_q <= 1'b0;
        end else begin
            sck_q <= SCK;
            if ($rose(BUSY)) n_lead <= 8'h00;
            else if (BUSY && SCK != CLK_POL && sck_q == CLK_POL) n_lead <= n_lead + 8'h01;
        end
    end
    a_start_busy: assert property (
        CTRL_STATUS[6] && CTRL_STATUS[0] && !BUSY && TX_VALID && TX_READY && !RX_VALID |-> ##[1:4] BUSY)
        else $error("Queued byte did not start");
    a_off_idle: assert property (!CTRL_STATUS[6] [*3] |-> !BUSY) else $error("Busy without master");
    a_fault_off: assert property (
        $fell(SLAVE_SELECT_N_IN) && CTRL_STATUS[3:2] == 2'b01 && CTRL_STATUS[0] ##1 !SLAVE_SELECT_N_IN [*3]
        |-> ##[0:3] CTRL_STATUS[6:5] == 2'b01 && !CTRL_STATUS[0]) else $error("No mode fault");
    a_irq_flag: assert property (
        $rose(CTRL_STATUS[7] || CTRL_STATUS[5]) && INT_EN |-> ##[0:1] IRQ) else $error("No interrupt");
    a_done_rx: assert property ($rose(CTRL_STATUS[7]) |-> ##[0:4] RX_VALID) else $error("No rx byte");
    a_byte_len: assert property (
        $fell(BUSY) && !CTRL_STATUS[5] |-> n_lead[2:0] == 3'h0 && n_lead != 8'h00)
        else $error("Partial byte");
    a_pin_in: assert property (!CTRL_STATUS[3] [*3] |-> SLAVE_SELECT_N_OE_N) else $error("Select driven");
    a_pin_out: assert property (CTRL_STATUS[3] [*3] |-> !SLAVE_SELECT_N_OE_N) else $error("Select not driven");
    a_ss_level: assert property (
        (CTRL_STATUS[3] && $stable(CTRL_STATUS[2])) [*3] |-> SLAVE_SELECT_N_OUT == CTRL_STATUS[2])
        else $error("Select level wrong");
    c_fault: cover property (CTRL_STATUS[5]);
    c_done: cover property ($rose(CTRL_STATUS[7]));
    c_four: cover property (!SLAVE_SELECT_N_OE_N);
endmodule : smm_master_checker
bind smm_master smm_master_checker u_chk (.CLK, .RST, .INT_EN, .CLK_POL, .TX_VALID, .TX_READY, .RX_VALID,
    .CTRL_STATUS, .IRQ, .BUSY, .SCK, .SLAVE_SELECT_N_IN, .SLAVE_SELECT_N_OUT, .SLAVE_SELECT_N_OE_N);

/* File: tb/smm_master_test.sv */
`timescale 1ns/10ps
//==========
// Bench
module smm_master_test;
    logic clk, rst, ctrl_wr, clk_pol, int_en, tx_valid, rx_ready, ss_in, sel_n, tx_ready, rx_valid;
    logic irq, busy, sck, mosi, miso, ss_out, ss_oe_n;
    logic [7:0] ctrl_wdata, clk_div, tx_data, rx_data, stat, reply;
    logic [7:0] bytes [6];
    logic [7:0] exp_q [$];
    logic [23:0] modes [4] = '{24'h0C0301, 24'h080300, 24'h000202, 24'h040202};
    int seed = 32'he8455402;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    smm_master uut (.CLK(clk), .RST(rst), .CTRL_WR(ctrl_wr), .CTRL_WDATA(ctrl_wdata), .CLK_DIV(clk_div),
        .CLK_POL(clk_pol), .INT_EN(int_en), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready), .CTRL_STATUS(stat), .IRQ(irq),
        .BUSY(busy), .SCK(sck), .MOSI(mosi), .MISO(miso), .SLAVE_SELECT_N_IN(ss_in),
        .SLAVE_SELECT_N_OUT(ss_out), .SLAVE_SELECT_N_OE_N(ss_oe_n));
    smm_slave_model u_slave (.sck(sck), .pol(clk_pol), .mosi(mosi), .sel_n(sel_n), .miso(miso));
    function automatic logic [7:0] slave_answer(input logic [7:0] b);
        return b ^ 8'hFF;
    endfunction : slave_answer
    task automatic conclude;
        $display("Checks %0d, errors %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("Error %0t: got %h want %h", $time, got, exp);
            fail_count++;
        end
    endtask : chk
    // Extra edges so the status has landed before it is read
    task automatic wr(input logic [7:0] v);
        ctrl_wdata <= v;
        ctrl_wr <= 1'b1;
        @(posedge clk);
        ctrl_wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : wr
    // Valid held until ready is seen high at an edge
    task automatic send(input logic [7:0] b);
        tx_data <= b;
        tx_valid <= 1'b1;
        do @(posedge clk); while (tx_ready !== 1'b1);
        tx_valid <= 1'b0;
        exp_q.push_back(reply);
        reply = slave_answer(b);
        @(posedge clk);
    endtask : send
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Random receive stalls fill the rx buffer
    always @(posedge clk) begin
        rx_ready <= 1'($random(seed));
        if (!rst && rx_valid && rx_ready) chk(rx_data, exp_q.pop_front());
    end
    // Ceiling far above six bytes at the slowest divider
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            $display("Error %0t: timeout", $time);
            fail_count++;
            conclude;
        end
    end
    initial begin
        {ctrl_wr, tx_valid, int_en, ss_in, sel_n, rst} = 6'h07;
        {ctrl_wdata, tx_data, reply} = 24'h00003C;
        clk_div = 8'h03 + 8'($random(seed) & 3);
        clk_pol = 1'($random(seed));
        for (int i = 1; i < 5; i++) bytes[i] = 8'($random(seed));
        bytes[0] = 8'h00;
        bytes[5] = 8'hFF;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Status launches on the first edge out of reset and is seen at the next
        repeat (2) @(posedge clk);
        chk(stat, 8'h04);
        int_en <= 1'b1;
        sel_n <= 1'b0;
        wr(8'h45);
        foreach (bytes[i]) send(bytes[i]);
        for (int k = 0; k < 4000 && (exp_q.size() != 0 || busy); k++) @(posedge clk);
        chk(8'(exp_q.size()), 8'h00);
        chk(stat & 8'hC1, 8'hC1);
        chk({7'h00, irq}, 8'h01);
        // Interrupt gating must follow the enable
        int_en <= 1'b0;
        repeat (2) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        int_en <= 1'b1;
        wr(8'h45);
        chk(stat & 8'h80, 8'h00);
        ss_in <= 1'b0;
        repeat (6) @(posedge clk);
        chk(stat & 8'h61, 8'h20);
        chk({7'h00, irq}, 8'h01);
        wr(8'h45);
        repeat (4) @(posedge clk);
        chk(stat & 8'h41, 8'h00);
        ss_in <= 1'b1;
        repeat (4) @(posedge clk);
        wr(8'h45);
        chk(stat & 8'h61, 8'h41);
        foreach (modes[i]) begin
            wr(modes[i][23:16]);
            chk({6'h00, ss_oe_n, ss_out} & modes[i][15:8], modes[i][7:0]);
        end
        conclude;
    end
endmodule : smm_master_test
